// ===== core/mftr_top.sv
// Multifunction terminal routing, speaker, ring/event and card buses
`timescale 1ns/1ns
module mftr_top
  import mftr_pkg::*;
#(
  parameter int unsigned ADDR_W   = CARD_ADDR_W,
  parameter int unsigned DATA_W   = CARD_DATA_W,
  parameter int unsigned HALF_CYC = SCL_HALF_CYC
) (
  input  wire logic              core_clk_i,
  input  wire logic              nrst_i,
  input  wire logic              global_reset_n_i,
  input  wire logic              pci_bus_reset_n_i,
  input  wire logic              suspend_n_i,
  input  wire logic              voltage_sense_0_i,
  input  wire logic              voltage_sense_1_i,
  input  wire mftr_route_t       route_i,
  input  wire logic              route_wr_i,
  input  wire mftr_src_t         src_i,
  input  wire logic              ring_sel_pme_i,
  input  wire logic              pme_i,
  input  wire logic              card_speaker_input_i,
  input  wire logic              card_audio_input_i,
  input  wire logic [ADDR_W-1:0] card_addr_i,
  input  wire logic [DATA_W-1:0] card_wdata_i,
  input  wire logic              card_data_drive_i,
  input  wire logic              multifunction_terminal_1_i,
  input  wire logic              multifunction_terminal_3_i,
  input  wire logic              multifunction_terminal_4_i,
  input  wire logic              multifunction_terminal_5_i,
  input  wire logic              multifunction_terminal_6_i,
  input  wire logic [DATA_W-1:0] card_data_i,
  output logic                   multifunction_terminal_1_o,
  output logic                   multifunction_terminal_1_oe_o,
  output logic                   multifunction_terminal_3_o,
  output logic                   multifunction_terminal_3_oe_o,
  output logic                   multifunction_terminal_4_o,
  output logic                   multifunction_terminal_4_oe_o,
  output logic                   multifunction_terminal_5_o,
  output logic                   multifunction_terminal_5_oe_o,
  output logic                   multifunction_terminal_6_o,
  output logic                   multifunction_terminal_6_oe_o,
  output logic                   general_input_3_o,
  output logic                   general_input_4_o,
  output logic                   serial_irq_in_o,
  output logic                   clkrun_in_o,
  output logic                   lock_in_o,
  output logic                   ring_indicate_output_o,
  output logic                   host_speaker_output_o,
  output logic [ADDR_W-1:0]      card_addr_o,
  output logic [DATA_W-1:0]      card_data_o,
  output logic                   card_data_oe_o,
  output logic [DATA_W-1:0]      card_rdata_o,
  output mftr_route_t            route_o,
  output logic                   ee_busy_o,
  output logic                   ee_done_o,
  output logic [EE_BYTES*8-1:0]  ee_data_o
);

  // Drive value for a selected source; oe low for input-only selections
  function automatic mftr_pin_t mftr_drive(input logic [SEL_W-1:0] sel,
                                           input mftr_src_t s);
    mftr_pin_t p;
    p = '{o: 1'b0, oe: 1'b1};
    unique case (sel)
      SEL_GPO:    p.o = s.general_output_3;
      SEL_LED:    p.o = s.led;
      SEL_VIDEO:  p.o = s.video;
      SEL_AUDIO:  p.o = s.audio_pwm;
      SEL_EVENT:  p.o = s.gen_event;
      SEL_D3:     p.o = s.d3_state;
      SEL_RING:   p.o = s.ring;
      SEL_IRQ:    p.o = s.irq;
      SEL_CLKRUN: p.o = s.clkrun;
      SEL_SERIRQ: p.o = s.serirq;
      default:    p.oe = 1'b0;
    endcase
    return p;
  endfunction : mftr_drive

  // Reject codes a terminal does not offer, falling back to its reset choice
  function automatic logic [SEL_W-1:0] mftr_legal(input logic [1:0] term,
                                                  input logic [SEL_W-1:0] s,
                                                  input logic [SEL_W-1:0] r);
    logic ok;
    ok = 1'b0;
    unique case (term)
      2'h0: ok = (s == SEL_IRQ) || (s == SEL_SERIRQ);
      2'h1: ok = (s <= SEL_LOCK);
      2'h2: ok = (s <= SEL_IRQ) && (s != SEL_RING);
      2'h3: ok = (s == SEL_IRQ) || (s == SEL_CLKRUN);
      default: ok = 1'b0;
    endcase
    return ok ? s : r;
  endfunction : mftr_legal

  // Routing and output registers are cleared by nrst_i always, and by the global or PCI reset unless suspend holds them
  logic sys_rst_n;
  logic ee_own;
  logic global_reset_input_d1_q, global_reset_input_d1_d;
  logic strap_q, strap_d;
  logic ee_start_q, ee_start_d;
  logic ee_scl_oe, ee_sda_oe, ee_busy, ee_done;
  logic [EE_BYTES*8-1:0] ee_data;
  mftr_route_t route_q, route_d;
  mftr_src_t   src4, src5;
  mftr_pin_t   p3, p4, p5, p6;

  assign sys_rst_n = nrst_i &
    ((global_reset_n_i & pci_bus_reset_n_i) | ~suspend_n_i);

  // Strap sampling on global reset release
  always_comb begin
    global_reset_input_d1_d  = global_reset_n_i;
    strap_d    = strap_q;
    ee_start_d = 1'b0;
    if (global_reset_n_i && !global_reset_input_d1_q) begin
      strap_d    = voltage_sense_0_i & voltage_sense_1_i;
      ee_start_d = voltage_sense_0_i & voltage_sense_1_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      global_reset_input_d1_q  <= 1'b0;
      strap_q    <= 1'b0;
      ee_start_q <= 1'b0;
    end else begin
      global_reset_input_d1_q  <= global_reset_input_d1_d;
      strap_q    <= strap_d;
      ee_start_q <= ee_start_d;
    end
  end

  mftr_eeprom_load #(
    .HALF_CYC (HALF_CYC),
    .NBYTES   (EE_BYTES)
  ) u_ee (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .start_i    (ee_start_q),
    .sda_i      (multifunction_terminal_1_i),
    .scl_oe_o   (ee_scl_oe),
    .sda_oe_o   (ee_sda_oe),
    .busy_o     (ee_busy),
    .done_o     (ee_done),
    .data_o     (ee_data)
  );

  // Terminal 4 is lent to the loader only until the load completes
  assign ee_own = strap_q & ~ee_done;

  // Routing register
  always_comb begin
    route_d = route_q;
    if (route_wr_i) begin
      route_d.t3 = mftr_legal(2'h0, route_i.t3, RST_SEL_T3);
      route_d.t4 = mftr_legal(2'h1, route_i.t4, RST_SEL_T4);
      route_d.t5 = mftr_legal(2'h2, route_i.t5, RST_SEL_T5);
      route_d.t6 = mftr_legal(2'h3, route_i.t6, RST_SEL_T6);
    end
  end

  always_ff @(posedge core_clk_i or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      route_q <= '{t3: RST_SEL_T3, t4: RST_SEL_T4,
                   t5: RST_SEL_T5, t6: RST_SEL_T6};
    end else begin
      route_q <= route_d;
    end
  end

  // Terminal 5 drives its own general output in the gpo slot
  always_comb begin
    src4      = src_i;
    src5      = src_i;
    src5.general_output_3 = src_i.general_output_4;
    p3 = mftr_drive(route_q.t3, src_i);
    p4 = mftr_drive(route_q.t4, src4);
    p5 = mftr_drive(route_q.t5, src5);
    p6 = mftr_drive(route_q.t6, src_i);
    // Lock is bidirectional: driven low-active only while asserted
    if (route_q.t4 == SEL_LOCK) begin
      p4 = '{o: 1'b0, oe: src_i.lock};
    end
    // Serial clock overrides terminal 4 while the strap holds and the load is not done
    if (ee_own) begin
      p4 = '{o: 1'b0, oe: ee_scl_oe};
    end
  end

  // Output registers: every top output comes from a flip-flop
  always_ff @(posedge core_clk_i or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      multifunction_terminal_1_o    <= 1'b0;
      multifunction_terminal_1_oe_o <= 1'b0;
      multifunction_terminal_3_o    <= 1'b0;
      multifunction_terminal_3_oe_o <= 1'b0;
      multifunction_terminal_4_o    <= 1'b0;
      multifunction_terminal_4_oe_o <= 1'b0;
      multifunction_terminal_5_o    <= 1'b0;
      multifunction_terminal_5_oe_o <= 1'b0;
      multifunction_terminal_6_o    <= 1'b0;
      multifunction_terminal_6_oe_o <= 1'b0;
      general_input_3_o             <= 1'b0;
      general_input_4_o             <= 1'b0;
      serial_irq_in_o               <= 1'b0;
      clkrun_in_o                   <= 1'b0;
      lock_in_o                     <= 1'b0;
      ring_indicate_output_o        <= 1'b0;
      host_speaker_output_o         <= 1'b0;
      card_addr_o                   <= '0;
      card_data_o                   <= '0;
      card_data_oe_o                <= 1'b0;
      card_rdata_o                  <= '0;
      route_o                       <= '0;
      ee_busy_o                     <= 1'b0;
      ee_done_o                     <= 1'b0;
      ee_data_o                     <= '0;
    end else begin
      multifunction_terminal_1_o    <= 1'b0;
      multifunction_terminal_1_oe_o <= strap_q & ee_sda_oe;
      multifunction_terminal_3_o    <= p3.o;
      multifunction_terminal_3_oe_o <= p3.oe;
      multifunction_terminal_4_o    <= p4.o;
      multifunction_terminal_4_oe_o <= p4.oe;
      multifunction_terminal_5_o    <= p5.o;
      multifunction_terminal_5_oe_o <= p5.oe;
      multifunction_terminal_6_o    <= p6.o;
      multifunction_terminal_6_oe_o <= p6.oe;
      general_input_3_o  <= (route_q.t4 == SEL_GPI) & ~ee_own &
                            multifunction_terminal_4_i;
      general_input_4_o  <= (route_q.t5 == SEL_GPI) &
                            multifunction_terminal_5_i;
      serial_irq_in_o    <= (route_q.t3 == SEL_SERIRQ) &
                            multifunction_terminal_3_i;
      clkrun_in_o        <= (route_q.t6 == SEL_CLKRUN) &
                            multifunction_terminal_6_i;
      lock_in_o          <= (route_q.t4 == SEL_LOCK) & ~ee_own &
                            multifunction_terminal_4_i;
      ring_indicate_output_o <= ring_sel_pme_i ? pme_i : src_i.ring;
      host_speaker_output_o  <= card_speaker_input_i ^
                                card_audio_input_i;
      card_addr_o    <= card_addr_i;
      card_data_o    <= card_wdata_i;
      card_data_oe_o <= card_data_drive_i;
      card_rdata_o   <= card_data_i;
      route_o        <= route_q;
      ee_busy_o      <= ee_busy;
      ee_done_o      <= ee_done;
      ee_data_o      <= ee_data;
    end
  end

endmodule : mftr_top

// ===== core/mftr_pkg.sv
// Constants and carrier types for the multifunction terminal router
package mftr_pkg;

  localparam int unsigned CARD_ADDR_W = 26;
  localparam int unsigned CARD_DATA_W = 16;
  localparam int unsigned SEL_W       = 4;
  localparam int unsigned EE_BYTES    = 4;

  // Routing selector codes, shared by multifunction terminals 3 to 6
  localparam logic [SEL_W-1:0] SEL_GPI    = 4'h0;
  localparam logic [SEL_W-1:0] SEL_GPO    = 4'h1;
  localparam logic [SEL_W-1:0] SEL_LED    = 4'h2;
  localparam logic [SEL_W-1:0] SEL_VIDEO  = 4'h3;
  localparam logic [SEL_W-1:0] SEL_AUDIO  = 4'h4;
  localparam logic [SEL_W-1:0] SEL_EVENT  = 4'h5;
  localparam logic [SEL_W-1:0] SEL_D3     = 4'h6;
  localparam logic [SEL_W-1:0] SEL_RING   = 4'h7;
  localparam logic [SEL_W-1:0] SEL_IRQ    = 4'h8;
  localparam logic [SEL_W-1:0] SEL_LOCK   = 4'h9;
  localparam logic [SEL_W-1:0] SEL_SERIRQ = 4'ha;
  localparam logic [SEL_W-1:0] SEL_CLKRUN = 4'hb;

  // Reset selections
  localparam logic [SEL_W-1:0] RST_SEL_T3 = SEL_SERIRQ;
  localparam logic [SEL_W-1:0] RST_SEL_T4 = SEL_GPI;
  localparam logic [SEL_W-1:0] RST_SEL_T5 = SEL_GPI;
  localparam logic [SEL_W-1:0] RST_SEL_T6 = SEL_CLKRUN;

  // Serial bus timing at 100 MHz
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SCL_HALF_NS   = 5000;
  localparam int unsigned SCL_HALF_CYC  = SCL_HALF_NS / CLK_PERIOD_NS;
  localparam logic [6:0]  EE_DEV_RD     = 7'h50;

  // Per-terminal routing selections
  typedef struct packed {
    logic [SEL_W-1:0] t3;
    logic [SEL_W-1:0] t4;
    logic [SEL_W-1:0] t5;
    logic [SEL_W-1:0] t6;
  } mftr_route_t;

  // Internal function sources that may be routed out
  typedef struct packed {
    logic general_output_3;
    logic general_output_4;
    logic led;
    logic video;
    logic audio_pwm;
    logic gen_event;
    logic d3_state;
    logic ring;
    logic irq;
    logic lock;
    logic serirq;
    logic clkrun;
  } mftr_src_t;

  // Pin pair: output, output enable
  typedef struct packed {
    logic o;
    logic oe;
  } mftr_pin_t;

endpackage : mftr_pkg

// ===== core/mftr_eeprom_load.sv
// Serial EEPROM default loader on the two-wire bus
`timescale 1ns/1ns
module mftr_eeprom_load
  import mftr_pkg::*;
#(
  parameter int unsigned HALF_CYC = SCL_HALF_CYC,
  parameter int unsigned NBYTES   = EE_BYTES
) (
  input  wire logic          core_clk_i,
  input  wire logic          nrst_i,
  input  wire logic          start_i,
  input  wire logic          sda_i,
  output logic               scl_oe_o,
  output logic               sda_oe_o,
  output logic               busy_o,
  output logic               done_o,
  output logic [NBYTES*8-1:0] data_o
);

  typedef enum logic [4:0] {
    MFTR_EE_IDLE = 5'b00001,
    MFTR_EE_STRT = 5'b00010,
    MFTR_EE_BIT  = 5'b00100,
    MFTR_EE_STOP = 5'b01000,
    MFTR_EE_DONE = 5'b10000
  } mftr_ee_st_t;

  localparam int unsigned FRAME_BITS = 9 + NBYTES * 9;

  mftr_ee_st_t         st_q, st_d;
  logic [15:0]         tick_q, tick_d;
  logic                ph_q, ph_d;
  logic [7:0]          bit_q, bit_d;
  logic [NBYTES*8-1:0] sh_q, sh_d;
  logic                scl_lo_q, scl_lo_d;
  logic                sda_lo_q, sda_lo_d;
  logic                half;
  logic [3:0]          slot;

  assign half = (tick_q == 16'(HALF_CYC - 1));
  assign slot = 4'(bit_q % 8'd9);

  // Open drain: the line is only ever pulled low
  always_comb begin
    st_d     = st_q;
    tick_d   = half ? 16'h0000 : tick_q + 16'h0001;
    ph_d     = ph_q;
    bit_d    = bit_q;
    sh_d     = sh_q;
    scl_lo_d = scl_lo_q;
    sda_lo_d = sda_lo_q;
    unique case (st_q)
      MFTR_EE_IDLE: begin
        tick_d = 16'h0000;
        if (start_i) begin
          st_d     = MFTR_EE_STRT;
          sda_lo_d = 1'b1;
        end
      end
      MFTR_EE_STRT: if (half) begin
        st_d     = MFTR_EE_BIT;
        scl_lo_d = 1'b1;
        bit_d    = 8'h00;
        ph_d     = 1'b0;
      end
      MFTR_EE_BIT: begin
        // Data moves mid-way through the low half, clear of both clock edges
        if (!ph_q && tick_q == 16'(HALF_CYC / 2)) begin
          if (bit_q < 8'd8) begin
            sda_lo_d = ~(bit_q == 8'd7 ? 1'b1
                                       : EE_DEV_RD[3'(6 - bit_q)]);
          end else if (slot == 4'h8) begin
            sda_lo_d = (bit_q > 8'd8) && (bit_q != 8'(FRAME_BITS - 1));
          end else begin
            sda_lo_d = 1'b0;
          end
        end
        if (half) begin
          ph_d = ~ph_q;
          if (!ph_q) begin
            scl_lo_d = 1'b0;
          end else begin
            scl_lo_d = 1'b1;
            if (bit_q > 8'd8 && slot != 4'h8) begin
              sh_d = {sh_q[NBYTES*8-2:0], sda_i};
            end
            bit_d = bit_q + 8'h01;
            if (bit_q == 8'(FRAME_BITS - 1)) begin
              st_d = MFTR_EE_STOP;
            end
          end
        end
      end
      MFTR_EE_STOP: begin
        if (scl_lo_q && tick_q == 16'(HALF_CYC / 2)) begin
          sda_lo_d = 1'b1;
        end
        if (half) begin
          if (scl_lo_q) begin
            scl_lo_d = 1'b0;
          end else begin
            sda_lo_d = 1'b0;
            st_d     = MFTR_EE_DONE;
          end
        end
      end
      MFTR_EE_DONE: st_d = MFTR_EE_DONE;
      default:      st_d = MFTR_EE_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q     <= MFTR_EE_IDLE;
      tick_q   <= 16'h0000;
      ph_q     <= 1'b0;
      bit_q    <= 8'h00;
      sh_q     <= '0;
      scl_lo_q <= 1'b0;
      sda_lo_q <= 1'b0;
    end else begin
      st_q     <= st_d;
      tick_q   <= tick_d;
      ph_q     <= ph_d;
      bit_q    <= bit_d;
      sh_q     <= sh_d;
      scl_lo_q <= scl_lo_d;
      sda_lo_q <= sda_lo_d;
    end
  end

  assign scl_oe_o = scl_lo_q;
  assign sda_oe_o = sda_lo_q;
  assign busy_o   = (st_q != MFTR_EE_IDLE) && (st_q != MFTR_EE_DONE);
  assign done_o   = (st_q == MFTR_EE_DONE);
  assign data_o   = sh_q;

endmodule : mftr_eeprom_load

// ===== verification/mftr_ee_model.sv
// Behavioural serial EEPROM on the two-wire default-load bus
`timescale 1ns/1ns
module mftr_ee_model #(
  parameter logic [31:0] ROM = 32'hc35a_1e96 // Arbitrary load image
) (
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_pull_o,
  output logic [7:0] addr_o,
  output logic [7:0] nbits_o,
  output logic [7:0] frame_o
);
  int k;
  initial begin
    sda_pull_o = 1'b0;
    addr_o = 8'h00;
    nbits_o = 8'h00;
    frame_o = 8'h00;
  end
  // Start: data falls while the clock is high
  always @(negedge sda_i) if (scl_i === 1'b1) nbits_o = 8'h00;
  // Stop costs one extra clock rise, so it is left out of the frame count
  always @(posedge sda_i) if (scl_i === 1'b1) frame_o = nbits_o - 8'h01;
  always @(posedge scl_i) begin
    if (nbits_o < 8'h08) addr_o = {addr_o[6:0], sda_i};
    nbits_o = nbits_o + 8'h01;
  end
  // Data moves only while the clock is low; released data floats high
  always @(negedge scl_i) begin
    k = int'(nbits_o) - 9;
    if (nbits_o == 8'h08) sda_pull_o = 1'b1;
    else if (k >= 0 && k < 36 && k % 9 < 8)
      sda_pull_o = !ROM[31 - (k / 9) * 8 - k % 9];
    else sda_pull_o = 1'b0;
  end
endmodule : mftr_ee_model

// ===== verification/mftr_top_chk.sv
// Concurrent checks on the multifunction terminal router ports
`timescale 1ns/1ns
module mftr_top_chk
  import mftr_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        nrst_i,
  input wire logic        global_reset_n_i,
  input wire logic        pci_bus_reset_n_i,
  input wire logic        suspend_n_i,
  input wire mftr_route_t route_i,
  input wire logic        route_wr_i,
  input wire mftr_src_t   src_i,
  input wire logic        ring_sel_pme_i,
  input wire logic        pme_i,
  input wire logic        card_speaker_input_i,
  input wire logic        card_audio_input_i,
  input wire logic        multifunction_terminal_1_o,
  input wire logic        multifunction_terminal_4_o,
  input wire logic        multifunction_terminal_4_oe_o,
  input wire logic        multifunction_terminal_5_oe_o,
  input wire logic        ring_indicate_output_o,
  input wire logic        host_speaker_output_o,
  input wire mftr_route_t route_o,
  input wire logic        ee_busy_o
);
  // Suspend masks the global and PCI resets
  wire logic rst_ok = nrst_i & ((global_reset_n_i & pci_bus_reset_n_i)
                                | ~suspend_n_i);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_ok);
  sequence t4_ok_wr_s;
    route_wr_i && route_i.t4 <= SEL_LOCK ##1 !route_wr_i;
  endsequence
  sequence t3_bad_wr_s;
    route_wr_i && route_i.t3 != SEL_IRQ && route_i.t3 != SEL_SERIRQ ##1 1'b1;
  endsequence
  spk_xor_a: assert property ($past(rst_ok) |->
    host_speaker_output_o == $past(card_speaker_input_i ^ card_audio_input_i))
    else $error("speaker output is not the xor of its inputs");
  ring_mux_a: assert property ($past(rst_ok) |->
    ring_indicate_output_o == $past(ring_sel_pme_i ? pme_i : src_i.ring))
    else $error("ring output does not follow its selected source");
  t4_route_a: assert property (t4_ok_wr_s |=>
    route_o.t4 == $past(route_i.t4, 2))
    else $error("terminal 4 selection not applied");
  t3_fallback_a: assert property (t3_bad_wr_s |=>
    route_o.t3 == RST_SEL_T3)
    else $error("terminal 3 illegal code kept");
  lock_pin_a: assert property (route_o.t4 == SEL_LOCK &&
    !ee_busy_o && !$past(ee_busy_o) |-> !multifunction_terminal_4_o &&
    multifunction_terminal_4_oe_o == $past(src_i.lock))
    else $error("terminal 4 lock drive wrong");
  gpi_float_a: assert property (route_o.t5 == SEL_GPI |->
    !multifunction_terminal_5_oe_o)
    else $error("terminal 5 driven while an input");
  serial_low_a: assert property ($past(ee_busy_o) && ee_busy_o |->
    !multifunction_terminal_4_o && !multifunction_terminal_1_o)
    else $error("serial bus driven high");
  suspend_hold_a: assert property (!suspend_n_i && $past(!suspend_n_i) &&
    (!pci_bus_reset_n_i || !global_reset_n_i) && !$past(route_wr_i) &&
    !$past(route_wr_i, 2) |-> $stable(route_o))
    else $error("routing lost under suspend");
endmodule : mftr_top_chk

bind mftr_top mftr_top_chk u_chk (.*);

// ===== verification/mftr_top_tb.sv
// Self-checking bench for the multifunction terminal router
`timescale 1ns/1ns
module mftr_top_tb;
  import mftr_pkg::*;
  localparam logic [31:0] ROM = 32'hc35a_1e96; // Arbitrary load image
  logic core_clk_i, nrst_i, global_reset_n_i, pci_bus_reset_n_i, suspend_n_i;
  logic voltage_sense_0_i, voltage_sense_1_i, route_wr_i, ring_sel_pme_i;
  logic pme_i, card_speaker_input_i, card_audio_input_i, card_data_drive_i;
  mftr_route_t route_i, route_o;
  mftr_src_t src_i;
  logic [25:0] card_addr_i, card_addr_o;
  logic [15:0] card_wdata_i, card_data_i, card_data_o, card_rdata_o;
  logic multifunction_terminal_1_i, multifunction_terminal_3_i;
  logic multifunction_terminal_4_i, multifunction_terminal_5_i;
  logic multifunction_terminal_6_i, multifunction_terminal_1_o;
  logic multifunction_terminal_3_o, multifunction_terminal_4_o;
  logic multifunction_terminal_5_o, multifunction_terminal_6_o;
  logic multifunction_terminal_1_oe_o, multifunction_terminal_3_oe_o;
  logic multifunction_terminal_4_oe_o, multifunction_terminal_5_oe_o;
  logic multifunction_terminal_6_oe_o, general_input_3_o, general_input_4_o;
  logic serial_irq_in_o, clkrun_in_o, lock_in_o, ring_indicate_output_o;
  logic host_speaker_output_o, card_data_oe_o, ee_busy_o, ee_done_o, sda_pull;
  logic [31:0] ee_data_o;
  logic [7:0] ee_addr, ee_bits, ee_frame;
  int num_errors = 0;
  int total_checks = 0;
  // Pins float high through board pull-ups when nobody drives them
  assign multifunction_terminal_1_i = ~sda_pull &
    (multifunction_terminal_1_oe_o ? multifunction_terminal_1_o : 1'b1);
  assign multifunction_terminal_3_i =
    multifunction_terminal_3_oe_o ? multifunction_terminal_3_o : 1'b1;
  assign multifunction_terminal_4_i =
    multifunction_terminal_4_oe_o ? multifunction_terminal_4_o : 1'b1;
  assign multifunction_terminal_5_i =
    multifunction_terminal_5_oe_o ? multifunction_terminal_5_o : 1'b1;
  assign multifunction_terminal_6_i =
    multifunction_terminal_6_oe_o ? multifunction_terminal_6_o : 1'b1;
  mftr_top #(.HALF_CYC(4)) u_mftr_top (.*);
  mftr_ee_model #(.ROM(ROM)) u_mftr_ee_model (
    .scl_i(multifunction_terminal_4_i), .sda_i(multifunction_terminal_1_i),
    .sda_pull_o(sda_pull), .addr_o(ee_addr), .nbits_o(ee_bits),
    .frame_o(ee_frame));

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic step(int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : step
  task automatic wr(logic [15:0] r);
    @(negedge core_clk_i);
    route_i = r;
    route_wr_i = 1'b1;
    @(negedge core_clk_i);
    route_wr_i = 1'b0;
    step(2);
  endtask : wr
  task automatic t_load();
    for (int n = 0; n < 3000 && ee_done_o !== 1'b1; n++) step(1);
    chk("ee_done", 32'h1, 32'(ee_done_o));
    chk("ee_data", ROM, ee_data_o);
    chk("ee_addr", {24'h0, EE_DEV_RD, 1'b1}, 32'(ee_addr));
    chk("ee_bits", 32'h2d, 32'(ee_frame));
  endtask : t_load
  task automatic t_audio();
    for (int i = 0; i < 8; i++) begin
      @(negedge core_clk_i);
      {card_speaker_input_i, card_audio_input_i} = 2'(i);
      {ring_sel_pme_i, pme_i, src_i.ring} = 3'(i);
      step(1);
      chk("spk", 32'(i[1] ^ i[0]), 32'(host_speaker_output_o));
      chk("ring", 32'(i[2] ? i[1] : i[0]), 32'(ring_indicate_output_o));
    end
  endtask : t_audio
  task automatic t_card();
    @(negedge core_clk_i);
    card_addr_i = 26'h2000001;
    card_wdata_i = 16'h8001;
    card_data_i = 16'h7ffe;
    card_data_drive_i = 1'b1;
    step(1);
    chk("addr", 32'h2000001, 32'(card_addr_o));
    chk("wdata", 32'h18001, {15'h0, card_data_oe_o, card_data_o});
    chk("rdata", 32'h7ffe, 32'(card_rdata_o));
  endtask : t_card
  task automatic t_route();
    logic [3:0] c, e3, e4, e5, e6;
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      e3 = (c == SEL_IRQ || c == SEL_SERIRQ) ? c : RST_SEL_T3;
      e4 = (c <= SEL_LOCK) ? c : RST_SEL_T4;
      e5 = (c <= SEL_IRQ && c != SEL_RING) ? c : RST_SEL_T5;
      e6 = (c == SEL_IRQ || c == SEL_CLKRUN) ? c : RST_SEL_T6;
      wr({c, c, c, c});
      chk("route", {16'h0, e3, e4, e5, e6}, 32'(route_o));
    end
  endtask : t_route
  task automatic t_pins();
    @(negedge core_clk_i);
    src_i = '0;
    src_i.general_output_4 = 1'b1;
    src_i.irq = 1'b1;
    src_i.lock = 1'b1;
    wr(16'h8918);
    chk("pin3", 32'h1, 32'(multifunction_terminal_3_o));
    chk("pin4", 32'h1, {multifunction_terminal_4_o,
                        multifunction_terminal_4_oe_o});
    chk("pin5", 32'h3, {multifunction_terminal_5_o,
                        multifunction_terminal_5_oe_o});
    chk("pin6", 32'h1, 32'(multifunction_terminal_6_o));
    wr(16'h8908);
    step(2);
    chk("gpi5", 32'h1, {multifunction_terminal_5_oe_o,
                        general_input_4_o});
  endtask : t_pins
  task automatic t_suspend();
    wr(16'h8988);
    @(negedge core_clk_i);
    voltage_sense_0_i = 1'b0;
    suspend_n_i = 1'b0;
    global_reset_n_i = 1'b0;
    pci_bus_reset_n_i = 1'b0;
    step(3);
    @(negedge core_clk_i);
    global_reset_n_i = 1'b1;
    pci_bus_reset_n_i = 1'b1;
    step(3);
    chk("hold", 32'h8988, 32'(route_o));
    @(negedge core_clk_i);
    suspend_n_i = 1'b1;
    pci_bus_reset_n_i = 1'b0;
    step(3);
    @(negedge core_clk_i);
    pci_bus_reset_n_i = 1'b1;
    step(3);
    chk("clear", 32'ha00b, 32'(route_o));
  endtask : t_suspend

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial begin
    {nrst_i, global_reset_n_i, pci_bus_reset_n_i, suspend_n_i} = 4'h3;
    {voltage_sense_0_i, voltage_sense_1_i} = 2'h3;
    {route_wr_i, ring_sel_pme_i, pme_i, card_data_drive_i} = 4'h0;
    {card_speaker_input_i, card_audio_input_i} = 2'h0;
    route_i = '0;
    src_i = '0;
    card_addr_i = 26'h0;
    card_wdata_i = 16'h0;
    card_data_i = 16'h0;
    repeat (8) @(posedge core_clk_i);
    @(negedge core_clk_i);
    nrst_i = 1'b1;
    @(negedge core_clk_i);
    global_reset_n_i = 1'b1;
    step(3);
    chk("route_rst", 32'ha00b, 32'(route_o));
    t_load();
    t_audio();
    t_card();
    t_route();
    t_pins();
    t_suspend();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge core_clk_i);
    num_errors++;
    close_out();
  end
endmodule : mftr_top_tb
